//--- src/crct_top.sv
/*
  Context return registers and cycle timer slice of the system registers.
  Assumes the pipeline gives one-cycle event strobes and a one-cycle
  system register write strobe; reads are combinational index, registered data.
*/
`timescale 1ns/1ps
`default_nettype none
module crct_top #(
  parameter int unsigned DATA_W = crct_pkg::DATA_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic mode_enter,
  input wire logic [2:0] mode_enter_ctx,
  input wire logic mode_return,
  input wire logic [2:0] mode_return_ctx,
  input wire logic debug_enter,
  input wire logic debug_return,
  input wire logic [DATA_W-1:0] status_word,
  input wire logic [DATA_W-1:0] reentry_address,
  input wire logic [DATA_W-1:0] program_counter,
  input wire logic bus_fault,
  input wire logic [DATA_W-1:0] bus_fault_addr_in,
  input wire logic sysreg_we,
  input wire logic [7:0] sysreg_idx,
  input wire logic [DATA_W-1:0] sysreg_wdata,
  output logic [DATA_W-1:0] sysreg_rdata,
  output logic status_load,
  output logic [DATA_W-1:0] status_restore,
  output logic pc_load,
  output logic [DATA_W-1:0] pc_restore,
  output logic compare_irq
);
  localparam int unsigned NCTX = crct_pkg::NUM_CTX;

  logic [DATA_W-1:0] saved_status_register [NCTX];
  logic [DATA_W-1:0] saved_return_address [NCTX];
  logic [DATA_W-1:0] debug_saved_status;
  logic [DATA_W-1:0] debug_return_address;
  logic [DATA_W-1:0] bytecode_operand_stack_pointer;
  logic [DATA_W-1:0] bus_fault_address;
  logic [DATA_W-1:0] count;
  logic [DATA_W-1:0] compare;
  logic timer_irq;
  logic count_we;
  logic compare_we;
  logic [DATA_W-1:0] next_rdata;

  assign count_we = sysreg_we && (sysreg_idx == crct_pkg::IDX_CYCLE_COUNT);
  assign compare_we = sysreg_we && (sysreg_idx == crct_pkg::IDX_CYCLE_COMPARE);

  crct_cycle_timer #(
    .WIDTH(DATA_W)
  ) u_timer (
    .clk(clk),
    .rst(rst),
    .count_we(count_we),
    .compare_we(compare_we),
    .wdata(sysreg_wdata),
    .count(count),
    .compare(compare),
    .compare_irq(timer_irq)
  );

  // registered copy keeps the output straight from a flip-flop
  always_ff @(posedge clk) begin
    if (rst) begin
      compare_irq <= 1'b0;
    end else begin
      compare_irq <= timer_irq;
    end
  end

  // hardware save wins over a software write landing in the same cycle
  for (genvar c = 0; c < NCTX; c++) begin : g_ctx
    always_ff @(posedge clk) begin
      if (rst) begin
        saved_status_register[c] <= crct_pkg::RESET_ZERO;
      end else if (mode_enter && mode_enter_ctx == 3'(c)) begin
        saved_status_register[c] <= status_word;
      end else if (sysreg_we
                   && sysreg_idx == crct_pkg::IDX_SAVED_STATUS_BASE + 8'(c)) begin
        saved_status_register[c] <= sysreg_wdata;
      end
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        saved_return_address[c] <= crct_pkg::RESET_ZERO;
      end else if (mode_enter && mode_enter_ctx == 3'(c)) begin
        saved_return_address[c] <= reentry_address;
      end else if (sysreg_we
                   && sysreg_idx == crct_pkg::IDX_RETURN_ADDRESS_BASE + 8'(c)) begin
        saved_return_address[c] <= sysreg_wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      debug_saved_status <= crct_pkg::RESET_ZERO;
      debug_return_address <= crct_pkg::RESET_ZERO;
    end else if (debug_enter) begin
      debug_saved_status <= status_word;
      debug_return_address <= program_counter;
    end else if (sysreg_we) begin
      if (sysreg_idx == crct_pkg::IDX_DEBUG_SAVED_STATUS) begin
        debug_saved_status <= sysreg_wdata;
      end
      if (sysreg_idx == crct_pkg::IDX_DEBUG_RETURN_ADDRESS) begin
        debug_return_address <= sysreg_wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      bytecode_operand_stack_pointer <= crct_pkg::RESET_ZERO;
    end else if (sysreg_we && sysreg_idx == crct_pkg::IDX_OPERAND_STACK_POINTER) begin
      bytecode_operand_stack_pointer <= sysreg_wdata;
    end
  end

  // no write path at all: software writes to this index are silently dropped
  always_ff @(posedge clk) begin
    if (rst) begin
      bus_fault_address <= crct_pkg::RESET_ZERO;
    end else if (bus_fault) begin
      bus_fault_address <= bus_fault_addr_in;
    end
  end

  // debug return takes priority if the pipeline ever raises both returns
  always_ff @(posedge clk) begin
    if (rst) begin
      status_load <= 1'b0;
      pc_load <= 1'b0;
      status_restore <= crct_pkg::RESET_ZERO;
      pc_restore <= crct_pkg::RESET_ZERO;
    end else begin
      status_load <= debug_return || mode_return;
      pc_load <= debug_return || mode_return;
      if (debug_return) begin
        status_restore <= debug_saved_status;
        pc_restore <= debug_return_address;
      end else if (mode_return) begin
        status_restore <= saved_status_register[mode_return_ctx];
        pc_restore <= saved_return_address[mode_return_ctx];
      end
    end
  end

  always_comb begin
    next_rdata = crct_pkg::RESET_ZERO;
    for (int i = 0; i < NCTX; i++) begin
      if (sysreg_idx == crct_pkg::IDX_SAVED_STATUS_BASE + 8'(i)) begin
        next_rdata = saved_status_register[i];
      end
      if (sysreg_idx == crct_pkg::IDX_RETURN_ADDRESS_BASE + 8'(i)) begin
        next_rdata = saved_return_address[i];
      end
    end
    unique case (sysreg_idx)
      crct_pkg::IDX_DEBUG_SAVED_STATUS: next_rdata = debug_saved_status;
      crct_pkg::IDX_DEBUG_RETURN_ADDRESS: next_rdata = debug_return_address;
      crct_pkg::IDX_OPERAND_STACK_POINTER: next_rdata = bytecode_operand_stack_pointer;
      crct_pkg::IDX_CYCLE_COUNT: next_rdata = count;
      crct_pkg::IDX_CYCLE_COMPARE: next_rdata = compare;
      crct_pkg::IDX_BUS_FAULT_ADDRESS: next_rdata = bus_fault_address;
      default: ;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sysreg_rdata <= crct_pkg::RESET_ZERO;
    end else begin
      sysreg_rdata <= next_rdata;
    end
  end

  a_enter_saves: assert property (@(posedge clk) disable iff (rst)
    mode_enter && mode_enter_ctx < 3'(NCTX) |=>
      saved_status_register[$past(mode_enter_ctx)] == $past(status_word))
    else $error("status not saved on mode entry");
  a_enter_addr: assert property (@(posedge clk) disable iff (rst)
    mode_enter && mode_enter_ctx < 3'(NCTX) |=>
      saved_return_address[$past(mode_enter_ctx)] == $past(reentry_address))
    else $error("re-entry address not saved");
  a_return_status: assert property (@(posedge clk) disable iff (rst)
    mode_return && !debug_return && !mode_enter |=> status_load && pc_load
      && status_restore == $past(saved_status_register[mode_return_ctx]))
    else $error("status not restored on return");
  a_return_pc: assert property (@(posedge clk) disable iff (rst)
    mode_return && !debug_return && !mode_enter |=>
      pc_restore == $past(saved_return_address[mode_return_ctx]))
    else $error("return address not used");
  a_debug_round: assert property (@(posedge clk) disable iff (rst)
    debug_enter ##1 debug_return |=>
      status_restore == $past(status_word, 2))
    else $error("debug status round trip broken");
  a_debug_pc: assert property (@(posedge clk) disable iff (rst)
    debug_enter ##1 debug_return |=>
      pc_restore == $past(program_counter, 2))
    else $error("debug pc round trip broken");
  a_fault_ro: assert property (@(posedge clk) disable iff (rst)
    !bus_fault |=> bus_fault_address == $past(bus_fault_address))
    else $error("bus fault address changed without fault");
  a_irq_out: assert property (@(posedge clk) disable iff (rst)
    timer_irq |=> compare_irq)
    else $error("request not driven out");
  a_debug_save: assert property (@(posedge clk) disable iff (rst)
    debug_enter |=> debug_saved_status == $past(status_word)
      && debug_return_address == $past(program_counter))
    else $error("debug entry did not save status and pc");
  a_load_quiet: assert property (@(posedge clk) disable iff (rst)
    !debug_return && !mode_return |=> !status_load && !pc_load)
    else $error("load pulse without a return");
  a_restore_hold: assert property (@(posedge clk) disable iff (rst)
    !debug_return && !mode_return |=> $stable(status_restore) && $stable(pc_restore))
    else $error("restore value changed without a return");
  a_fault_capture: assert property (@(posedge clk) disable iff (rst)
    bus_fault |=> bus_fault_address == $past(bus_fault_addr_in))
    else $error("bus fault address not captured");
  a_count_write: assert property (@(posedge clk) disable iff (rst)
    count_we |=> count == $past(sysreg_wdata))
    else $error("count write not taken");
  a_compare_write: assert property (@(posedge clk) disable iff (rst)
    compare_we |=> compare == $past(sysreg_wdata))
    else $error("compare write not taken");
  a_count_read: assert property (@(posedge clk) disable iff (rst)
    sysreg_idx == crct_pkg::IDX_CYCLE_COUNT |=> sysreg_rdata == $past(count))
    else $error("count read returned wrong value");
endmodule
`default_nettype wire

//--- src/crct_pkg.sv
/*
  Package for the context return and cycle timer slice: system register
  indices, context codes, field widths and reset values.
  Assumes the pipeline addresses system registers by word index.
*/
package crct_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned IDX_W = 8;
  localparam int unsigned CTX_W = 3;
  localparam int unsigned NUM_CTX = 7;

  // context codes for the banked return registers
  typedef enum logic [2:0] {
    CRCT_CTX_SUP = 3'h0,
    CRCT_CTX_IRQ0 = 3'h1,
    CRCT_CTX_IRQ1 = 3'h2,
    CRCT_CTX_IRQ2 = 3'h3,
    CRCT_CTX_IRQ3 = 3'h4,
    CRCT_CTX_EXC = 3'h5,
    CRCT_CTX_NMI = 3'h6
  } crct_ctx_t;

  // system register indices (byte address is four times the index)
  localparam logic [7:0] IDX_SAVED_STATUS_BASE = 8'h02;
  localparam logic [7:0] IDX_DEBUG_SAVED_STATUS = 8'h09;
  localparam logic [7:0] IDX_RETURN_ADDRESS_BASE = 8'h0a;
  localparam logic [7:0] IDX_DEBUG_RETURN_ADDRESS = 8'h11;
  localparam logic [7:0] IDX_OPERAND_STACK_POINTER = 8'h13;
  localparam logic [7:0] IDX_CYCLE_COUNT = 8'h42;
  localparam logic [7:0] IDX_CYCLE_COMPARE = 8'h43;
  localparam logic [7:0] IDX_BUS_FAULT_ADDRESS = 8'h4f;

  localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
  localparam logic [31:0] COUNT_STEP = 32'h0000_0001;
endpackage

//--- src/crct_cycle_timer.sv
/*
  Free-running cycle counter with compare interrupt request.
  Assumes writes come from the system register port of the top module.
*/
`timescale 1ns/1ps
`default_nettype none
module crct_cycle_timer #(
  parameter int unsigned WIDTH = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic count_we,
  input wire logic compare_we,
  input wire logic [WIDTH-1:0] wdata,
  output logic [WIDTH-1:0] count,
  output logic [WIDTH-1:0] compare,
  output logic compare_irq
);
  logic match;

  // a match is only meaningful while compare is non-zero
  assign match = (compare != WIDTH'(0)) && (count == compare);

  // no enable input exists on purpose: the count never stops
  always_ff @(posedge clk) begin
    if (rst) begin
      count <= WIDTH'(crct_pkg::RESET_ZERO);
    end else if (count_we) begin
      count <= wdata;
    end else begin
      count <= count + WIDTH'(crct_pkg::COUNT_STEP);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      compare <= WIDTH'(crct_pkg::RESET_ZERO);
    end else if (compare_we) begin
      compare <= wdata;
    end
  end

  // a compare write clears the request; the new value cannot match this cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      compare_irq <= 1'b0;
    end else if (compare_we) begin
      compare_irq <= 1'b0;
    end else if (match) begin
      compare_irq <= 1'b1;
    end
  end

  a_count_steps: assert property (@(posedge clk) disable iff (rst)
    !count_we |=> count == $past(count) + WIDTH'(1))
    else $error("count did not advance");
  a_count_pending: assert property (@(posedge clk) disable iff (rst)
    compare_irq && !count_we |=> count != $past(count))
    else $error("count stalled while request pending");
  a_irq_on_match: assert property (@(posedge clk) disable iff (rst)
    match && !compare_we |=> compare_irq)
    else $error("match did not raise request");
  a_irq_cleared: assert property (@(posedge clk) disable iff (rst)
    compare_we |=> !compare_irq)
    else $error("compare write left request pending");
  a_zero_quiet: assert property (@(posedge clk) disable iff (rst)
    !compare_irq && compare == WIDTH'(0) |=> !compare_irq)
    else $error("request raised with zero compare");
  a_count_wraps: assert property (@(posedge clk) disable iff (rst)
    count == '1 && !count_we |=> count == WIDTH'(0))
    else $error("count did not wrap to zero");
endmodule
`default_nettype wire

//--- bench/crct_irq_ctrl_model.sv
/*
  Stand-in for the interrupt controller: counts compare requests it forwards.
  Assumes the request arrives as a level from the timer slice.
*/
`timescale 1ns/1ps
`default_nettype none
module crct_irq_ctrl_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic irq_req,
  output var int unsigned forwarded
);
  logic seen;
  // one forward per episode; priority choice stays outside this slice
  always_ff @(posedge clk) begin
    if (rst) begin
      seen <= 1'b0;
      forwarded <= 0;
    end else begin
      seen <= irq_req;
      if (irq_req && !seen) begin
        forwarded <= forwarded + 1;
      end
    end
  end
endmodule
`default_nettype wire

//--- bench/tb_context_return_and_cycle_timer.sv
/*
  Self-checking bench for the context return and cycle timer slice.
  Assumes the design's sync reset and the registered read path.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_context_return_and_cycle_timer;
  logic clk, rst, mode_enter, mode_return, debug_enter, debug_return, bus_fault, sysreg_we;
  logic [2:0] mode_enter_ctx, mode_return_ctx;
  logic [31:0] status_word, reentry_address, program_counter, bus_fault_addr_in, sysreg_wdata;
  logic [7:0] sysreg_idx;
  logic [31:0] sysreg_rdata, status_restore, pc_restore, v;
  logic status_load, pc_load, compare_irq;
  int unsigned forwarded;
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;
  // bench model of the banked registers; slot 7 is the debug pair
  logic [31:0] sav_st [8];
  logic [31:0] sav_ra [8];

  crct_top dut (.clk(clk), .rst(rst), .mode_enter(mode_enter), .mode_enter_ctx(mode_enter_ctx),
    .mode_return(mode_return), .mode_return_ctx(mode_return_ctx), .debug_enter(debug_enter),
    .debug_return(debug_return), .status_word(status_word), .reentry_address(reentry_address),
    .program_counter(program_counter), .bus_fault(bus_fault),
    .bus_fault_addr_in(bus_fault_addr_in), .sysreg_we(sysreg_we), .sysreg_idx(sysreg_idx),
    .sysreg_wdata(sysreg_wdata), .sysreg_rdata(sysreg_rdata), .status_load(status_load),
    .status_restore(status_restore), .pc_load(pc_load), .pc_restore(pc_restore),
    .compare_irq(compare_irq));
  crct_irq_ctrl_model irq_ctrl (.clk(clk), .rst(rst), .irq_req(compare_irq),
    .forwarded(forwarded));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic wrap_up;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      wrap_up();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    @(posedge clk);
    sysreg_idx <= i;
    sysreg_wdata <= d;
    sysreg_we <= 1'b1;
    @(posedge clk);
    sysreg_we <= 1'b0;
  endtask

  // read data is registered: it shows the register one edge after the index
  task automatic rd(input logic [7:0] i, input logic [31:0] exp, input string what);
    @(posedge clk);
    sysreg_idx <= i;
    @(posedge clk);
    #1 check(what, sysreg_rdata, exp);
  endtask

  task automatic enter(input logic dbg, input logic [2:0] c);
    logic [31:0] s, r;
    s = $urandom;
    r = $urandom;
    // context code 7 is ignored by the design, so the model keeps slot 7
    if (dbg || c != 3'h7) begin
      sav_st[dbg ? 3'h7 : c] = s;
      sav_ra[dbg ? 3'h7 : c] = r;
    end
    @(posedge clk);
    status_word <= s;
    reentry_address <= r;
    program_counter <= r;
    if (dbg) debug_enter <= 1'b1;
    else mode_enter <= 1'b1;
    mode_enter_ctx <= c;
    @(posedge clk);
    debug_enter <= 1'b0;
    mode_enter <= 1'b0;
  endtask

  task automatic ret(input logic dbg, input logic [2:0] c);
    @(posedge clk);
    if (dbg) debug_return <= 1'b1;
    else mode_return <= 1'b1;
    mode_return_ctx <= c;
    @(posedge clk);
    debug_return <= 1'b0;
    mode_return <= 1'b0;
    #1 check("status_load", status_load, 1);
    check("pc_load", pc_load, 1);
    check("status_restore", status_restore, sav_st[dbg ? 3'h7 : c]);
    check("pc_restore", pc_restore, sav_ra[dbg ? 3'h7 : c]);
  endtask

  initial begin
    {rst, mode_enter, mode_return, debug_enter, debug_return, bus_fault, sysreg_we} = 7'h7f;
    {mode_enter, mode_return, debug_enter, debug_return, bus_fault, sysreg_we} = 6'h00;
    {mode_enter_ctx, mode_return_ctx, sysreg_idx} = 14'h0000;
    {status_word, reentry_address, program_counter, bus_fault_addr_in, sysreg_wdata} = '0;
    void'($urandom(33));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(8'h13, 32'h0000_0000, "operand stack pointer");
    rd(8'h43, 32'h0000_0000, "compare after reset");
    check("irq after reset", compare_irq, 0);
    $display("test reset done");

    for (int c = 0; c < 8; c++) enter(1'b0, c[2:0]);
    enter(1'b1, 3'h0);
    for (int c = 0; c < 8; c++) begin
      rd(8'h02 + c[7:0], sav_st[c], "saved status");
      rd(8'h0a + c[7:0], sav_ra[c], "return address");
    end
    for (int c = 0; c < 7; c++) ret(1'b0, c[2:0]);
    ret(1'b1, 3'h0);
    // debug entry and return on adjacent edges: the shortest round trip
    v = $urandom;
    sav_st[7] = v;
    sav_ra[7] = ~v;
    @(posedge clk);
    status_word <= v;
    program_counter <= ~v;
    debug_enter <= 1'b1;
    @(posedge clk);
    debug_enter <= 1'b0;
    debug_return <= 1'b1;
    @(posedge clk);
    debug_return <= 1'b0;
    #1 check("debug round status", status_restore, sav_st[7]);
    check("debug round pc", pc_restore, sav_ra[7]);
    $display("test contexts done");

    v = $urandom;
    wr(8'h42, v);
    rd(8'h42, v + 32'h0000_0001, "count written");
    wr(8'h42, 32'hffff_ffff);
    rd(8'h42, 32'h0000_0000, "count wrap");
    $display("test count done");

    wr(8'h43, 32'h0000_0100);
    rd(8'h43, 32'h0000_0100, "compare written");
    wr(8'h42, 32'h0000_00f0);
    // match after 16 edges, request one edge later, output one more
    repeat (17) @(posedge clk);
    #1 check("irq before match", compare_irq, 0);
    @(posedge clk);
    #1 check("irq on match", compare_irq, 1);
    rd(8'h42, 32'h0000_0103, "count while pending");
    check("irq held", compare_irq, 1);
    check("forwarded", forwarded, 1);
    wr(8'h43, 32'h0000_0100);
    @(posedge clk);
    #1 check("irq after compare write", compare_irq, 0);
    wr(8'h43, 32'h0000_0000);
    wr(8'h42, 32'hffff_fff0);
    repeat (40) begin
      @(posedge clk);
      #1 check("irq with zero compare", compare_irq, 0);
    end
    $display("test compare done");

    v = $urandom;
    @(posedge clk);
    bus_fault <= 1'b1;
    bus_fault_addr_in <= v;
    @(posedge clk);
    bus_fault <= 1'b0;
    rd(8'h4f, v, "bus fault address");
    wr(8'h4f, ~v);
    rd(8'h4f, v, "bus fault address after write");
    rd(8'h55, 32'h0000_0000, "unmapped");
    $display("test bus fault done");
    wrap_up();
  end
endmodule
`default_nettype wire
